// ===== design/tvi_arbiter.sv
// Two-level fixed-order arbitration of requesting sources
`timescale 1ns/1ps
module tvi_arbiter #(
	parameter int NSRC = tvi_pkg::NUM_SRC
) (
	// Requests and levels
	input wire logic [NSRC-1:0] req,
	input wire logic [NSRC-1:0] high,
	input wire logic act_lo,
	input wire logic act_hi,
	// Winner
	output logic valid,
	output logic [3:0] idx,
	output logic win_hi
);
	logic [NSRC-1:0] hi_req, lo_req;

	function automatic logic [3:0] first_set(input logic [NSRC-1:0] v);
		first_set = 4'h0;
		for (int i = NSRC - 1; i >= 0; i--)
			if (v[i])
				first_set = 4'(i);
	endfunction

	// A running high routine blocks all; a running low routine blocks low
	assign hi_req = act_hi ? '0 : (req & high);
	assign lo_req = (act_hi || act_lo) ? '0 : (req & ~high);

	always_comb
	begin
		valid = (|hi_req) || (|lo_req);
		win_hi = |hi_req;
		idx = win_hi ? first_set(hi_req) : first_set(lo_req);
	end
endmodule

// ===== design/tvi_ext_input.sv
// Conditioning of one external interrupt input
`timescale 1ns/1ps
module tvi_ext_input (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Pin and configuration
	input wire logic [7:0] port0_pins,
	input wire logic [2:0] pin_sel,
	input wire logic polarity,
	input wire logic sense_edge,
	// Flag control
	input wire logic sw_wr,
	input wire logic sw_val,
	input wire logic vec_clr,
	output logic pending
);
	typedef struct packed {
		logic prev;
		logic flag;
	} tvi_ext_t;
	tvi_ext_t s, next_s;
	logic active;

	// Pin is only observed, never driven
	assign active = polarity ? port0_pins[pin_sel] : ~port0_pins[pin_sel];
	assign pending = s.flag;

	always_comb
	begin
		next_s = s;
		next_s.prev = active;
		if (!sense_edge)
			next_s.flag = active;
		else
		begin
			if (sw_wr)
				next_s.flag = sw_val;
			else if (vec_clr)
				next_s.flag = 1'b0;
			if (active && !s.prev)
				next_s.flag = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			s <= '0;
		else
			s <= next_s;
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_level_follow: assert property (!sense_edge |=> $past(sense_edge) || pending == $past(active))
		else $error("level flag does not follow input");
	a_edge_sets: assert property (sense_edge && active && !s.prev |=> pending)
		else $error("active edge lost");
endmodule

// ===== design/tvi_top.sv
// Two-level vectored interrupt unit: registers, request, nesting and vector
`timescale 1ns/1ps

module tvi_top (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Special function register port
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	output logic [7:0] sfr_rdata,
	output logic sfr_hit,
	// Processor sequencer
	input wire logic inst_done,
	input wire logic irq_take,
	input wire logic return_from_interrupt_done,
	output logic irq_req,
	output logic irq_high,
	output logic [15:0] irq_vector,
	// Peripheral flags and external pins
	input wire logic [14:0] periph_flag,
	input wire logic [7:0] port0_pins,
	input wire logic [1:0] ext_sense_sel,
	input wire logic [1:0] ext_pend_wr,
	input wire logic [1:0] ext_pend_wdata,
	output logic [1:0] ext_pending,
	output logic [1:0] clr_timer_flag,
	output logic global_irq_enable
);
	typedef struct packed {
		logic [7:0] ie;
		logic [7:0] ip;
		logic [7:0] eie;
		logic [7:0] eip;
		logic [7:0] cfg;
		logic act_lo;
		logic act_hi;
		logic hold;
		logic req;
		logic hi;
		logic [3:0] idx;
		logic [15:0] vec;
	} tvi_state_t;
	tvi_state_t s, next_s;

	logic [14:0] enables, prios, pend, req_vec;
	logic arb_valid, arb_hi, taken;
	logic [3:0] arb_idx;
	logic [1:0] ext_clr;
	logic [7:0] ie_now, eie_now;

	// ==========================================================
	// External inputs
	// Edge flags of the external inputs clear on their own vector
	assign taken = irq_take && s.req;
	assign ext_clr[0] = taken && s.idx == tvi_pkg::SRC_EXT_A;
	assign ext_clr[1] = taken && s.idx == tvi_pkg::SRC_EXT_B;

	tvi_ext_input u_ext_a (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.port0_pins(port0_pins),
		.pin_sel(s.cfg[tvi_pkg::CFG_A_SEL +: 3]),
		.polarity(s.cfg[tvi_pkg::CFG_A_POL]),
		.sense_edge(ext_sense_sel[0]),
		.sw_wr(ext_pend_wr[0]),
		.sw_val(ext_pend_wdata[0]),
		.vec_clr(ext_clr[0]),
		.pending(ext_pending[0])
	);

	tvi_ext_input u_ext_b (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.port0_pins(port0_pins),
		.pin_sel(s.cfg[tvi_pkg::CFG_B_SEL +: 3]),
		.polarity(s.cfg[tvi_pkg::CFG_B_POL]),
		.sense_edge(ext_sense_sel[1]),
		.sw_wr(ext_pend_wr[1]),
		.sw_val(ext_pend_wdata[1]),
		.vec_clr(ext_clr[1]),
		.pending(ext_pending[1])
	);

	// ==========================================================
	// Request vector
	// Flags count whether or not enabled; a software-set flag looks the same
	always_comb
	begin
		pend = periph_flag;
		pend[tvi_pkg::SRC_EXT_A] = ext_pending[0];
		pend[tvi_pkg::SRC_EXT_B] = ext_pending[1];
	end

	// Enables taken from the value being written, so a clearing write
	// already blocks the request registered at this edge
	always_comb
	begin
		ie_now = s.ie;
		eie_now = s.eie;
		if (sfr_wr && sfr_addr == tvi_pkg::ADDR_IE)
			ie_now = sfr_wdata;
		if (sfr_wr && sfr_addr == tvi_pkg::ADDR_EIE)
			eie_now = sfr_wdata & tvi_pkg::EXT_WMASK;
	end

	assign enables = tvi_pkg::src_map(ie_now, eie_now);
	assign prios = tvi_pkg::src_map(s.ip, s.eip);
	assign req_vec = pend & enables & {15{ie_now[tvi_pkg::GLOBAL_EN_BIT]}};

	// Winner of both levels; busy levels mask their requests
	tvi_arbiter #(
		.NSRC(tvi_pkg::NUM_SRC)
	) u_arb (
		.req(req_vec),
		.high(prios),
		.act_lo(s.act_lo),
		.act_hi(s.act_hi),
		.valid(arb_valid),
		.idx(arb_idx),
		.win_hi(arb_hi)
	);

	// ==========================================================
	// Register and sequencing logic
	always_comb
	begin
		next_s = s;
		if (sfr_wr)
		begin
			case (sfr_addr)
				tvi_pkg::ADDR_IE: next_s.ie = sfr_wdata;
				tvi_pkg::ADDR_IP: next_s.ip = sfr_wdata | tvi_pkg::IP_FIXED;
				tvi_pkg::ADDR_CFG: next_s.cfg = sfr_wdata;
				tvi_pkg::ADDR_EIE: next_s.eie = sfr_wdata & tvi_pkg::EXT_WMASK;
				tvi_pkg::ADDR_EIP: next_s.eip = sfr_wdata & tvi_pkg::EXT_WMASK;
				default: next_s.ie = s.ie;
			endcase
		end
		// Entering a routine marks its level busy
		if (taken)
		begin
			if (s.hi)
				next_s.act_hi = 1'b1;
			else
				next_s.act_lo = 1'b1;
		end
		// Return releases the innermost level and defers one instruction
		if (return_from_interrupt_done)
		begin
			if (s.act_hi)
				next_s.act_hi = 1'b0;
			else
				next_s.act_lo = 1'b0;
			next_s.hold = 1'b1;
		end
		else if (inst_done)
			next_s.hold = 1'b0;
		// Sampled and decoded every clock; one clock of detection
		next_s.req = arb_valid && !next_s.hold && !taken && !return_from_interrupt_done;
		if (arb_valid)
		begin
			next_s.hi = arb_hi;
			next_s.idx = arb_idx;
			next_s.vec = tvi_pkg::vec_of(arb_idx);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s <= '0;
			s.ie <= tvi_pkg::RST_IE;
			s.ip <= tvi_pkg::RST_IP;
			s.eie <= tvi_pkg::RST_EIE;
			s.eip <= tvi_pkg::RST_EIP;
			s.cfg <= tvi_pkg::RST_CFG;
		end
		else
			s <= next_s;
	end

	// ==========================================================
	// Outputs
	assign irq_req = s.req;
	assign irq_high = s.hi;
	assign irq_vector = s.vec;
	assign global_irq_enable = s.ie[tvi_pkg::GLOBAL_EN_BIT];
	// Timer overflow flags live in the timers; pulse them clear
	assign clr_timer_flag[0] = taken && s.idx == tvi_pkg::SRC_TIMER0;
	assign clr_timer_flag[1] = taken && s.idx == tvi_pkg::SRC_TIMER1;

	// Unmapped addresses read zero and drop the hit flag
	always_comb
	begin
		sfr_hit = 1'b1;
		case (sfr_addr)
			tvi_pkg::ADDR_IE: sfr_rdata = s.ie;
			tvi_pkg::ADDR_IP: sfr_rdata = s.ip;
			tvi_pkg::ADDR_CFG: sfr_rdata = s.cfg;
			tvi_pkg::ADDR_EIE: sfr_rdata = s.eie;
			tvi_pkg::ADDR_EIP: sfr_rdata = s.eip;
			default:
			begin
				sfr_rdata = 8'h00;
				sfr_hit = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// Checks
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_global_gate: assert property (!global_irq_enable && !(sfr_wr && sfr_addr == tvi_pkg::ADDR_IE)
		|=> !irq_req)
		else $error("request while globally disabled");
	a_ea_clear_blocks: assert property (sfr_wr && sfr_addr == tvi_pkg::ADDR_IE && !sfr_wdata[7]
		|=> !irq_req)
		else $error("request after enable cleared");
	a_return_from_interrupt_defers: assert property (return_from_interrupt_done ##1 !inst_done |=> !irq_req)
		else $error("request before instruction after return");
	a_reenter_next: assert property (s.hold && inst_done && !return_from_interrupt_done && !irq_take && arb_valid
		|=> irq_req)
		else $error("no re-entry after one instruction");
	a_detect_clock: assert property (arb_valid && !s.hold && !irq_take && !return_from_interrupt_done
		|=> irq_req && irq_high == $past(arb_hi))
		else $error("request not raised one clock after detect");
	a_hi_no_preempt: assert property (s.act_hi |-> !irq_req)
		else $error("high routine preempted");
	a_lo_only_high: assert property (s.act_lo && irq_req |-> irq_high)
		else $error("low routine preempted by low request");
	a_vector_slot: assert property (irq_req |-> irq_vector[2:0] == 3'h3
		&& irq_vector <= 16'h0073 && irq_vector != 16'h0043 && irq_vector != 16'h006b)
		else $error("vector outside fixed slots");
	a_timer_clear: assert property (irq_take && irq_req && irq_vector == 16'h000b
		|-> clr_timer_flag == 2'b01)
		else $error("timer flag not cleared on vectoring");
	a_nest_level: assert property (irq_take && irq_req && irq_high |=> s.act_hi)
		else $error("high level not marked active");

	// Vectoring side effects and level bookkeeping
	a_take_drops: assert property (irq_take && irq_req |=> !irq_req)
		else $error("request stands after call started");
	a_timer1_clear: assert property (irq_take && irq_req && irq_vector == 16'h001b
		|-> clr_timer_flag == 2'b10)
		else $error("timer 1 flag not cleared on vectoring");
	a_no_sw_clear: assert property (irq_take && irq_req && irq_vector > 16'h001b
		|-> clr_timer_flag == 2'b00 && ext_clr == 2'b00)
		else $error("software-cleared flag cleared by hardware");
	a_ext_vec_clear: assert property (irq_take && irq_req && irq_vector == 16'h0013
		|-> ext_clr == 2'b10)
		else $error("external flag not cleared on vectoring");
	a_lo_marked: assert property (irq_take && irq_req && !irq_high
		|=> s.act_lo)
		else $error("low level not marked active");
	a_hi_release: assert property (return_from_interrupt_done && s.act_hi
		|=> !s.act_hi)
		else $error("high level not released on return");
	a_lo_release: assert property (return_from_interrupt_done && !s.act_hi
		|=> !s.act_lo)
		else $error("low level not released on return");

	c_low_taken: cover property (irq_take && irq_req && !irq_high);
	c_preempt: cover property (s.act_lo && irq_take && irq_req && irq_high);
	c_return_from_interrupt_reenter: cover property (return_from_interrupt_done ##[1:20] irq_req);
	c_ext_edge: cover property (ext_clr[0]);
	c_ext_b_edge: cover property (ext_clr[1]);
endmodule

// ===== inc/tvi_pkg.sv
// Constants and helpers of the two-level vectored interrupt unit
package tvi_pkg;
	// ==========================================================
	// Register addresses and reset values
	localparam logic [7:0] ADDR_IE = 8'ha8;
	localparam logic [7:0] ADDR_IP = 8'hb8;
	localparam logic [7:0] ADDR_CFG = 8'he4;
	localparam logic [7:0] ADDR_EIE = 8'he6;
	localparam logic [7:0] ADDR_EIP = 8'hf6;
	localparam logic [7:0] RST_IE = 8'h00;
	localparam logic [7:0] RST_IP = 8'h80;
	localparam logic [7:0] RST_CFG = 8'h01;
	localparam logic [7:0] RST_EIE = 8'h00;
	localparam logic [7:0] RST_EIP = 8'h00;
	// Read-only one in the main priority register, writable bits of the extended ones
	localparam logic [7:0] IP_FIXED = 8'h80;
	localparam logic [7:0] EXT_WMASK = 8'hbd;
	// ==========================================================
	// Field positions
	localparam int GLOBAL_EN_BIT = 7;
	localparam int CFG_B_POL = 7;
	localparam int CFG_B_SEL = 4;
	localparam int CFG_A_POL = 3;
	localparam int CFG_A_SEL = 0;
	// ==========================================================
	// Sources and vectors
	localparam int NUM_SRC = 15;
	localparam logic [3:0] SRC_EXT_A = 4'h0;
	localparam logic [3:0] SRC_TIMER0 = 4'h1;
	localparam logic [3:0] SRC_EXT_B = 4'h2;
	localparam logic [3:0] SRC_TIMER1 = 4'h3;
	localparam logic [15:0] VEC_BASE = 16'h0003;
	localparam logic [15:0] VEC_STEP = 16'h0008;
	// ==========================================================
	// Response timing in system clocks
	localparam int DETECT_CYC = 1;
	localparam int CALL_CYC = 4;
	localparam int MIN_RESPONSE = DETECT_CYC + CALL_CYC;

	// Spreads main and extended byte onto the fifteen priority-order slots
	function automatic logic [14:0] src_map(input logic [7:0] main, input logic [7:0] ext);
		src_map = {ext[7], 1'b0, ext[5:2], 1'b0, ext[0], main[6:0]};
	endfunction

	function automatic logic [15:0] vec_of(input logic [3:0] idx);
		vec_of = VEC_BASE + VEC_STEP * {12'h000, idx};
	endfunction
endpackage

// ===== tb/tvi_core_model.sv
// Behavioural processor sequencer facing the interrupt unit
`timescale 1ns/1ps
module tvi_core_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Bench control
	input wire logic run,
	input wire logic slow,
	input wire logic return_from_interrupt_cmd,
	// Interrupt unit
	input wire logic irq_req,
	output logic inst_done,
	output logic irq_take,
	output logic return_from_interrupt_done
);
	logic odd;
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			odd <= 1'b0;
			inst_done <= 1'b0;
			irq_take <= 1'b0;
			return_from_interrupt_done <= 1'b0;
		end
		else
		begin
			odd <= ~odd;
			return_from_interrupt_done <= return_from_interrupt_cmd;
			// Slow mode ends an instruction every other clock
			inst_done <= run && !return_from_interrupt_cmd && !irq_take && (!slow || odd);
			// Call starts on the clock after a request, whether or not an instruction has ended
			irq_take <= run && irq_req && !irq_take && !return_from_interrupt_cmd;
		end
	end
endmodule

// ===== tb/two_level_vectored_interrupt_unit_test.sv
// Self-checking bench of the two-level vectored interrupt unit
`timescale 1ns/1ps
module two_level_vectored_interrupt_unit_test;
	logic core_clk;
	logic rst_n;
	logic [7:0] sfr_addr;
	logic [7:0] sfr_wdata;
	logic sfr_wr;
	logic [7:0] sfr_rdata;
	logic sfr_hit;
	logic inst_done;
	logic irq_take;
	logic return_from_interrupt_done;
	logic irq_req;
	logic irq_high;
	logic [15:0] irq_vector;
	logic [14:0] periph_flag;
	logic [7:0] port0_pins;
	logic [1:0] ext_sense_sel;
	logic [1:0] ext_pend_wr;
	logic [1:0] ext_pend_wdata;
	logic [1:0] ext_pending;
	logic [1:0] clr_timer_flag;
	logic global_irq_enable;
	logic run;
	logic slow;
	logic return_from_interrupt_cmd;
	int num_errors = 0;
	int tests_run = 0;

	tvi_top dut_u (.core_clk(core_clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
		.inst_done(inst_done), .irq_take(irq_take), .return_from_interrupt_done(return_from_interrupt_done),
		.irq_req(irq_req), .irq_high(irq_high), .irq_vector(irq_vector),
		.periph_flag(periph_flag), .port0_pins(port0_pins), .ext_sense_sel(ext_sense_sel),
		.ext_pend_wr(ext_pend_wr), .ext_pend_wdata(ext_pend_wdata),
		.ext_pending(ext_pending), .clr_timer_flag(clr_timer_flag),
		.global_irq_enable(global_irq_enable));
	tvi_core_model core_u (.core_clk(core_clk), .rst_n(rst_n), .run(run), .slow(slow),
		.return_from_interrupt_cmd(return_from_interrupt_cmd), .irq_req(irq_req), .inst_done(inst_done),
		.irq_take(irq_take), .return_from_interrupt_done(return_from_interrupt_done));

	// ==========================================================
	// Shared tasks
	task automatic final_report();
		if (num_errors == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		cyc(1);
		sfr_wr = 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		sfr_addr = a;
		#1;
		chk({8'h00, sfr_rdata}, {8'h00, exp});
	endtask
	task automatic wait_take(input logic [1:0] clr, input logic [15:0] vec);
		int n;
		n = 0;
		while (irq_take !== 1'b1 && n < 20)
		begin
			cyc(1);
			n++;
		end
		chk(irq_take, 1'b1);
		chk(irq_vector, vec);
		chk(clr_timer_flag, clr);
		run = 1'b0;
	endtask
	task automatic return_from_interrupt();
		return_from_interrupt_cmd = 1'b1;
		cyc(1);
		return_from_interrupt_cmd = 1'b0;
		cyc(3);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_regs();
		rd_chk(8'ha8, 8'h00);
		chk(sfr_hit, 1'b1);
		rd_chk(8'hb8, 8'h80);
		rd_chk(8'he4, 8'h01);
		rd_chk(8'hf6, 8'h00);
		rd_chk(8'h55, 8'h00);
		chk(sfr_hit, 1'b0);
		wr_reg(8'hb8, 8'h00);
		rd_chk(8'hb8, 8'h80);
		wr_reg(8'ha8, 8'h81);
		rd_chk(8'ha8, 8'h81);
		chk(global_irq_enable, 1'b1);
	endtask
	task automatic t_vectors();
		wr_reg(8'ha8, 8'hff);
		wr_reg(8'he6, 8'hbd);
		for (int s = 1; s < 15; s++)
		begin
			if (s != 2 && s != 8 && s != 13)
			begin
				periph_flag = 15'h0001 << s;
				cyc(2);
				chk(irq_req, 1'b1);
				chk(irq_vector, 16'h0003 + 16'(8 * s));
			end
		end
		wr_reg(8'he6, 8'h3d);
		cyc(1);
		chk(irq_req, 1'b0);
		wr_reg(8'he6, 8'hbd);
		periph_flag = 15'h7efa;
		cyc(2);
		chk(irq_vector, 16'h000b);
		wr_reg(8'hf6, 8'h80);
		cyc(1);
		chk(irq_vector, 16'h0073);
		chk(irq_high, 1'b1);
		// Core stays idle after the clear, as a two-byte follower would
		wr_reg(8'ha8, 8'h7f);
		chk(irq_req, 1'b0);
		cyc(2);
		chk(irq_req, 1'b0);
		wr_reg(8'hf6, 8'h00);
		periph_flag = 15'h0000;
	endtask
	task automatic t_nest();
		wr_reg(8'ha8, 8'h82);
		periph_flag = 15'h0002;
		run = 1'b1;
		wait_take(2'b01, 16'h000b);
		periph_flag = 15'h0000;
		return_from_interrupt();
		wr_reg(8'ha8, 8'h90);
		periph_flag = 15'h0010;
		run = 1'b1;
		wait_take(2'b00, 16'h0023);
		wr_reg(8'he6, 8'h80);
		wr_reg(8'hf6, 8'h80);
		periph_flag = 15'h4010;
		cyc(2);
		chk(irq_req, 1'b1);
		chk(irq_high, 1'b1);
		run = 1'b1;
		wait_take(2'b00, 16'h0073);
		wr_reg(8'hb8, 8'h20);
		wr_reg(8'ha8, 8'hb0);
		periph_flag = 15'h0030;
		cyc(3);
		chk(irq_req, 1'b0);
		return_from_interrupt();
		chk(irq_req, 1'b0);
		run = 1'b1;
		wait_take(2'b00, 16'h002b);
		chk(irq_high, 1'b1);
		periph_flag = 15'h0010;
		return_from_interrupt();
		chk(irq_req, 1'b0);
		return_from_interrupt();
		chk(irq_req, 1'b0);
		run = 1'b1;
		wait_take(2'b00, 16'h0023);
		periph_flag = 15'h0000;
		return_from_interrupt();
	endtask
	task automatic t_ext();
		wr_reg(8'he4, 8'h0b);
		ext_sense_sel = 2'b00;
		port0_pins = 8'h09;
		cyc(2);
		chk(ext_pending, 2'b01);
		port0_pins = 8'hf7;
		cyc(2);
		chk(ext_pending, 2'b00);
		wr_reg(8'he4, 8'h60);
		ext_sense_sel = 2'b10;
		port0_pins = 8'hff;
		cyc(2);
		port0_pins = 8'hbf;
		cyc(2);
		chk(ext_pending, 2'b10);
		// Requester lets go before service ends
		port0_pins = 8'hff;
		cyc(2);
		chk(ext_pending, 2'b10);
		wr_reg(8'ha8, 8'h84);
		slow = 1'b1;
		run = 1'b1;
		wait_take(2'b00, 16'h0013);
		cyc(1);
		chk(ext_pending, 2'b00);
		return_from_interrupt();
		ext_pend_wr = 2'b10;
		ext_pend_wdata = 2'b10;
		cyc(1);
		ext_pend_wr = 2'b00;
		run = 1'b1;
		wait_take(2'b00, 16'h0013);
		return_from_interrupt();
	endtask

	// ==========================================================
	// Clock, watchdog and main sequence
	initial
	begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	initial
	begin
		#1000000;
		num_errors++;
		final_report();
	end
	initial
	begin
		rst_n = 1'b0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		sfr_wr = 1'b0;
		periph_flag = 15'h0000;
		port0_pins = 8'hff;
		ext_sense_sel = 2'b00;
		ext_pend_wr = 2'b00;
		ext_pend_wdata = 2'b00;
		run = 1'b0;
		slow = 1'b0;
		return_from_interrupt_cmd = 1'b0;
		cyc(8);
		rst_n = 1'b1;
		cyc(1);
		t_regs();
		t_vectors();
		t_nest();
		t_ext();
		final_report();
	end
endmodule
